// >>> rtl/spld_regs.svh
// Constants of the serial power latch driver.
// Assumes inclusion by the driver package and top module only.
`ifndef SPLD_REGS_SVH
`define SPLD_REGS_SVH
`define SPLD_WIDTH      8
`define SPLD_FIFO_DEPTH 8
`define SPLD_CLEAR_VAL  8'h00
`endif

// >>> rtl/spld_pkg.sv
// Types of the serial power latch driver.
// Assumes spld_regs.svh is on the include path.
`include "spld_regs.svh"
package spld_pkg;
    typedef logic [`SPLD_WIDTH-1:0] spld_byte_t;
endpackage

// >>> rtl/spld_top.sv
// Serial-in latch driver with eight open-drain sink outputs and a latch-data FIFO.
// Assumes all pin inputs are asynchronous to clk and are synchronised here.
`include "spld_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module spld_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Fill side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    assign in_ready  = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_nxt  = push ? AW'(wr_r + 1'b1) : wr_r;
        rd_nxt  = pop ? AW'(rd_r + 1'b1) : rd_r;
        cnt_nxt = (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage needs no reset; a word is read only after it was written.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    // The counter never passes the depth, so in_ready really blocks an overflow.
    a_fifo_count: assert property (@(posedge clk) disable iff (sys_rst)
        cnt_r <= (AW+1)'(DEPTH))
        else $error("queue count above depth");
endmodule // spld_fifo

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - An 8-bit shift register takes serial bits in and offers all eight stages in parallel.
// - Each shift_clock rising edge while shift_clear_n is high shifts one place, bit_stream_in entering stage 0.
// - Each latch_clock rising edge copies the shift register into the storage register.
// - While shift_clear_n is low every shift stage is held at zero.
// - While the output gate is high all output buffer bits are low.
// - While the output gate is low the output buffers follow storage directly.
// - cascade_out carries shift register data onward to a chained device.
// - A sink output is off at buffer bit zero and sinks current at buffer bit one.
module spld_top (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // Host pins.
    input  wire logic                 bit_stream_in,
    input  wire logic                 shift_clock,
    input  wire logic                 latch_clock,
    input  wire logic                 shift_clear_n,
    input  wire logic                 output_gate_n,
    // Chain and sink pins; sink_outputs_oe high means the sink transistor is on.
    output logic                      cascade_out,
    output logic                      sink_outputs_o,
    output logic [`SPLD_WIDTH-1:0]    sink_outputs_oe,
    // Back-pressure: latch_ready low and latch_fifo_full high while the latch FIFO is full.
    output logic                      latch_ready,
    output logic                      latch_fifo_full
);
    // Two-flop synchronisers; stage one is read only by stage two.
    // Reset values match the idle pin levels, so no false clock edge follows reset.
    logic [4:0] meta_r, sync_r;
    logic [1:0] sync_q_r;
    logic       ser_s, sck_s, lck_s, clr_n_s, gate_n_s, sck_q, lck_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r   <= 5'h18;
            sync_r   <= 5'h18;
            sync_q_r <= 2'h0;
        end else begin
            meta_r   <= {output_gate_n, shift_clear_n, latch_clock, shift_clock, bit_stream_in};
            sync_r   <= meta_r;
            sync_q_r <= sync_r[2:1];
        end
    end
    assign ser_s    = sync_r[0];
    assign sck_s    = sync_r[1];
    assign lck_s    = sync_r[2];
    assign clr_n_s  = sync_r[3];
    assign gate_n_s = sync_r[4];
    assign sck_q    = sync_q_r[0];
    assign lck_q    = sync_q_r[1];

    logic sck_rise, lck_rise;
    assign sck_rise = sck_s && !sck_q;
    assign lck_rise = lck_s && !lck_q;

    ////////////////////////////////////////////////////////////////////////////
    spld_pkg::spld_byte_t shift_r, shift_nxt, store_r, store_nxt, buf_r, buf_nxt;
    logic                 cas_r, cas_nxt;
    logic                 fifo_valid;
    spld_pkg::spld_byte_t fifo_data;

    always_comb begin
        shift_nxt = shift_r;
        cas_nxt   = cas_r;
        if (!clr_n_s) begin
            shift_nxt = `SPLD_CLEAR_VAL;
            cas_nxt   = 1'b0;
        end else if (sck_rise) begin
            shift_nxt = {shift_r[`SPLD_WIDTH-2:0], ser_s};
            cas_nxt   = shift_r[`SPLD_WIDTH-2];
        end
        // Latched words queue in the FIFO; storage takes one per cycle.
        store_nxt = fifo_valid ? fifo_data : store_r;
        buf_nxt   = gate_n_s ? `SPLD_CLEAR_VAL : store_nxt;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_r <= `SPLD_CLEAR_VAL;
            cas_r   <= 1'b0;
            store_r <= `SPLD_CLEAR_VAL;
            buf_r   <= `SPLD_CLEAR_VAL;
        end else begin
            shift_r <= shift_nxt;
            cas_r   <= cas_nxt;
            store_r <= store_nxt;
            buf_r   <= buf_nxt;
        end
    end

    // A latch edge arriving while full is dropped; latch_ready warns the host.
    spld_fifo #(.WIDTH(`SPLD_WIDTH), .DEPTH(`SPLD_FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (lck_rise),
        .in_ready  (latch_ready),
        .in_data   (shift_r),
        .out_valid (fifo_valid),
        .out_ready (1'b1),
        .out_data  (fifo_data)
    );
    assign latch_fifo_full = !latch_ready;

    assign cascade_out     = cas_r;
    assign sink_outputs_o  = 1'b0;  // Open drain: only ever pulls low.
    assign sink_outputs_oe = buf_r;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_shift_edge;
        clr_n_s && sck_rise;
    endsequence

    // Pushes into an empty FIFO only, so the word reaches storage two cycles later.
    sequence s_latch_push;
        lck_rise && latch_ready && !fifo_valid;
    endsequence

    a_shift_advance: assert property (@(posedge clk) disable iff (sys_rst)
        s_shift_edge |=> shift_r == {$past(shift_r[6:0]), $past(ser_s)})
        else $error("shift register did not advance");
    a_shift_clear: assert property (@(posedge clk) disable iff (sys_rst)
        !clr_n_s |=> shift_r == 8'h00)
        else $error("shift register not cleared");
    a_clear_cascade: assert property (@(posedge clk) disable iff (sys_rst)
        !clr_n_s |=> cascade_out == 1'b0)
        else $error("cascade output not cleared");
    a_cascade_tail: assert property (@(posedge clk) disable iff (sys_rst)
        s_shift_edge |=> cascade_out == $past(shift_r[6]))
        else $error("cascade output wrong");
    a_cascade_stage: assert property (@(posedge clk) disable iff (sys_rst)
        cascade_out == shift_r[`SPLD_WIDTH-1])
        else $error("cascade output is not the last stage");
    a_latch_capture: assert property (@(posedge clk) disable iff (sys_rst)
        s_latch_push |=> ##1 store_r == $past(shift_r, 2))
        else $error("storage did not capture");
    a_store_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !fifo_valid |=> $stable(store_r))
        else $error("storage changed without a latch edge");
    // Latch edges are at least two cycles apart and the drain never stalls.
    a_fifo_drain: assert property (@(posedge clk) disable iff (sys_rst)
        fifo_valid |=> !fifo_valid)
        else $error("latched word waited in the queue");
    // Buffers load from the same next value as storage, so the sinks match storage in the same cycle; only the gate acts one cycle late.
    a_latch_to_sink: assert property (@(posedge clk) disable iff (sys_rst)
        s_latch_push ##2 !gate_n_s |=> sink_outputs_oe == $past(shift_r, 3))
        else $error("latched word did not reach the sinks");
    a_gate_off: assert property (@(posedge clk) disable iff (sys_rst)
        gate_n_s |=> sink_outputs_oe == 8'h00)
        else $error("outputs on while gated");
    a_gate_follow: assert property (@(posedge clk) disable iff (sys_rst)
        !gate_n_s |=> buf_r == store_r)
        else $error("buffers do not follow storage");
    a_sink_map: assert property (@(posedge clk) disable iff (sys_rst)
        $past(!gate_n_s) |-> sink_outputs_oe == store_r && sink_outputs_o == 1'b0)
        else $error("sink drive mismatch");
    a_cascade_hold: assert property (@(posedge clk) disable iff (sys_rst)
        clr_n_s && !sck_rise |=> $stable(cascade_out))
        else $error("cascade changed without shift edge");
endmodule // spld_top

// >>> sim/spld_host.sv
// Host controller model that drives the serial pins of the latch driver.
// Assumes clk is the driver's clock; every pin changes on its falling edge.
module spld_host (
    // Clock.
    input  wire logic clk,
    // Host pins.
    output logic      bit_stream_in,
    output logic      shift_clock,
    output logic      latch_clock,
    output logic      shift_clear_n,
    output logic      output_gate_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        bit_stream_in = 1'b0;
        shift_clock = 1'b0;
        latch_clock = 1'b0;
        shift_clear_n = 1'b1;
        output_gate_n = 1'b1;
    end
    // Four cycles a side, twice what the pin synchroniser needs.
    task automatic pulse(input bit latch);
        repeat (4) @(negedge clk);
        if (latch) latch_clock = 1'b1;
        else shift_clock = 1'b1;
        repeat (4) @(negedge clk);
        shift_clock = 1'b0;
        latch_clock = 1'b0;
    endtask
    task automatic shift_bit(input logic b);
        shift_clear_n = 1'b1;
        bit_stream_in = b;
        pulse(1'b0);
        // Hold has run out, so the line no longer shows the old bit.
        bit_stream_in = ~b;
        @(negedge clk);
    endtask
    task automatic shift_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) shift_bit(v[i]);
    endtask
    task automatic clear();
        shift_clear_n = 1'b0;
        repeat (6) @(negedge clk);
        shift_clear_n = 1'b1;
    endtask
    task automatic set_gate(input logic g);
        output_gate_n = g;
    endtask
endmodule // spld_host

// >>> sim/spld_top_tb.sv
// Self-checking bench for the serial latch driver.
// Assumes the host model in spld_host.sv drives every pin input.
module spld_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic din, sck, lck, clr_n, gate_n, casc, sink_o, rdy, full;
    spld_pkg::spld_byte_t oe;
    int n_errors = 0;
    int n_checks = 0;
    initial forever #20 clk = ~clk;
    spld_host host (.clk(clk), .bit_stream_in(din), .shift_clock(sck), .latch_clock(lck),
        .shift_clear_n(clr_n), .output_gate_n(gate_n));
    spld_top DUT (.clk(clk), .sys_rst(sys_rst), .bit_stream_in(din), .shift_clock(sck),
        .latch_clock(lck), .shift_clear_n(clr_n), .output_gate_n(gate_n),
        .cascade_out(casc), .sink_outputs_o(sink_o), .sink_outputs_oe(oe),
        .latch_ready(rdy), .latch_fifo_full(full));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic load(input logic [7:0] v);
        host.shift_byte(v);
        host.pulse(1'b1);
        repeat (8) @(negedge clk);
    endtask
    task automatic t_load();
        load(8'hA5);
        check(oe, 8'h00);
        check({6'h00, rdy, full}, 8'h02);
        host.set_gate(1'b0);
        repeat (6) @(negedge clk);
        check(oe, 8'hA5);
        check({7'h00, sink_o}, 8'h00);
    endtask
    task automatic t_cascade();
        logic [7:0] sent = 8'hA5;
        for (int i = 7; i >= 0; i--) begin
            check({7'h00, casc}, {7'h00, sent[i]});
            host.shift_bit(1'b0);
        end
        // Shifting without a latch edge must leave the outputs alone.
        check(oe, 8'hA5);
    endtask
    task automatic t_gate();
        load(8'h3C);
        check(oe, 8'h3C);
        host.set_gate(1'b1);
        repeat (6) @(negedge clk);
        check(oe, 8'h00);
        host.set_gate(1'b0);
        repeat (6) @(negedge clk);
        check(oe, 8'h3C);
    endtask
    task automatic t_clear();
        host.shift_byte(8'hFF);
        host.clear();
        check({7'h00, casc}, 8'h00);
        host.pulse(1'b1);
        repeat (8) @(negedge clk);
        check(oe, 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        t_load();
        t_cascade();
        t_gate();
        t_clear();
        final_report();
    end
    // The tests need about 360 cycles; 6000, over sixteen times that, means a hang.
    initial begin
        repeat (6000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule // spld_top_tb
